/* rtl/salnk_pkg.sv */
// shared definitions for the shared area link allocator
package salnk_pkg;
  // register byte offsets on the apb
  localparam logic [7:0] SALNK_OFS_PARAM  = 8'h00; // link parameter word
  localparam logic [7:0] SALNK_OFS_STATUS = 8'h04; // run/valid/mode status
  localparam logic [7:0] SALNK_OFS_NODE   = 8'h08; // local node address
  localparam logic [7:0] SALNK_OFS_TABLE  = 8'h0C; // manual table entry write port
  localparam logic [7:0] SALNK_OFS_TSEL   = 8'h10; // node select for readback
  localparam logic [7:0] SALNK_OFS_TRD    = 8'h14; // table entry readback
  localparam logic [7:0] SALNK_OFS_FIFO   = 8'h18; // refresh word push
  localparam logic [7:0] SALNK_OFS_FSTAT  = 8'h1C; // fifo level

  // parameter word fields
  localparam int SALNK_BIT_RUN    = 0;
  localparam int SALNK_POS_MODE   = 4;
  localparam int SALNK_POS_WPN    = 6;
  localparam logic [15:0] SALNK_PARAM_RST = 16'h0000;

  // automatic area bases and sizes
  localparam logic [15:0] SALNK_CIO_BASE  = 16'h03E8;
  localparam logic [15:0] SALNK_DM_BASE   = 16'h0000;
  localparam logic [15:0] SALNK_CIO_WORDS = 16'h0040;
  localparam logic [15:0] SALNK_DM_WORDS  = 16'h0080;
  localparam logic [15:0] SALNK_CIO_MIN   = 16'h0004;
  localparam logic [15:0] SALNK_DM_MIN    = 16'h0008;
  localparam int          SALNK_MAX_NODES = 62;
  localparam logic [5:0]  SALNK_NODE_RST  = 6'h00;
  localparam logic [5:0]  SALNK_TSEL_RST  = 6'h01;

  typedef enum logic [1:0] {
    SALNK_MODE_MANUAL = 2'b00,
    SALNK_MODE_CIO    = 2'b01,
    SALNK_MODE_DM     = 2'b10,
    SALNK_MODE_BOTH   = 2'b11
  } salnk_mode_t;

  typedef enum logic [2:0] {
    SALNK_ST_IDLE  = 3'b001,
    SALNK_ST_CHECK = 3'b010,
    SALNK_ST_RUN   = 3'b100
  } salnk_state_t;

  // one table entry: area starts and word counts
  typedef struct packed {
    logic [15:0] cio_start;
    logic [7:0]  cio_cnt;
    logic [15:0] dm_start;
    logic [7:0]  dm_cnt;
  } salnk_entry_t;

  // one word that leaves over the link during refresh
  typedef struct packed {
    logic        is_dm;
    logic [15:0] addr;
    logic [15:0] data;
  } salnk_word_t;
endpackage

/* rtl/salnk_fifo.sv */
// small synchronous fifo for refresh words
`timescale 1ns/1ps
module salnk_fifo
  import salnk_pkg::*;
#(
  parameter int WIDTH = 33,
  parameter int DEPTH = 32
) (
  input  wire logic             mclk,    // clock
  input  wire logic             sys_rst, // sync reset
  input  wire logic [WIDTH-1:0] in_data, // write data
  input  wire logic             in_valid,// write request
  output logic                  in_ready,// not full
  output logic [WIDTH-1:0]      out_data,// head word, registered
  output logic                  out_valid,// head valid
  input  wire logic             out_ready,// drain accepts
  output logic [$clog2(DEPTH):0] level   // words held
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0]      wp;
    logic [AW:0]      rp;
    logic [WIDTH-1:0] head;
    logic             hv;
  } salnk_fifo_st_t;

  logic [WIDTH-1:0] mem [DEPTH];
  salnk_fifo_st_t   s_q, s_d;
  logic             push, pop_mem, mem_has;

  assign mem_has   = (s_q.wp != s_q.rp);
  // the head register counts toward capacity, so the whole queue holds DEPTH words
  assign in_ready  = (level < (AW+1)'(DEPTH));
  assign push      = in_valid && in_ready;
  // head register refills when empty or drained, so output data stays registered
  assign pop_mem   = mem_has && (!s_q.hv || out_ready);
  assign out_data  = s_q.head;
  assign out_valid = s_q.hv;
  assign level     = (AW+1)'(s_q.wp - s_q.rp) + (AW+1)'(s_q.hv);

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop_mem) begin
      s_d.rp   = s_q.rp + 1'b1;
      s_d.head = mem[s_q.rp[AW-1:0]];
      s_d.hv   = 1'b1;
    end else if (out_ready) begin
      s_d.hv = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
    if (push) begin
      mem[s_q.wp[AW-1:0]] <= in_data;
    end
  end
endmodule

/* rtl/salnk_top.sv */
// shared area link allocator: parameter decode, link table and refresh path
`timescale 1ns/1ps
// What this block does
// - parameter bits 5:4 = 01 core io, 10 data memory, 11 both automatic
// - bits 5:4 = 00 selects manual mode using stored tables
// - bits 7:6 pick 4/8/16/32 core io and 8/16/32/64 data words
// - automatic blocks ascend from 1000 and 0, ending at 1063 and 127
// - automatic node count is 16, 8, 4 or 2 from words per node
// - automatic mode gives every node an identical equal-size entry
// - manual entries differ per node, any subset up to 62 nodes
// - settings used are those of the startup node
// - links start when the control bit turns on, stop when off
// - control is bit 0 of the parameter word, one enables
// - links do not run while mode or table settings are invalid
// - link areas must be contiguous; gaps between nodes are rejected
// - manual tables are kept in a backup table, host-visible in manual mode only
// - local node address comes from the rotary switches
// - only local node words may be written; they go to every node
module salnk_top
  import salnk_pkg::*;
#(
  parameter int FIFO_DEPTH = 32,
  parameter int NODES      = SALNK_MAX_NODES
) (
  input  wire logic        mclk,         // 25 MHz clock
  input  wire logic        sys_rst,      // sync reset, active high
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb enable
  input  wire logic        pwrite,       // apb direction
  input  wire logic [7:0]  paddr,        // apb byte address
  input  wire logic [31:0] pwdata,       // apb write data
  output logic [31:0]      prdata,       // apb read data
  output logic             pready,       // apb ready
  output logic             pslverr,      // apb error
  input  wire logic [5:0]  rotary_node,  // front-panel node address switches
  input  wire logic        startup_node, // this node is the startup node
  input  wire logic [15:0] net_param,    // parameter word broadcast by startup node
  output logic             link_run,     // data links running
  output logic [32:0]      tx_word,      // refresh word to network
  output logic             tx_valid,     // refresh word valid
  input  wire logic        tx_ready      // network accepts word
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [15:0]  param;
    logic [5:0]   node;
    logic [5:0]   tsel;
    salnk_state_t st;
    logic         valid;
    logic         run;
    logic [31:0]  rdata;
    logic         ready;
    logic         err;
    logic         tbl_we;
    logic [5:0]   tbl_idx;
    salnk_entry_t tbl_wd;
    logic [NODES-1:0] used;
  } salnk_st_t;

  salnk_st_t    s_q, s_d;
  salnk_entry_t tbl [NODES];
  salnk_entry_t auto_e, lo_e, node_e;
  logic [15:0]  eff_param;
  salnk_mode_t  mode;
  logic [15:0]  cio_w, dm_w;
  logic [5:0]   n_nodes;
  logic         setup, access, wr, rd, tbl_ok;
  logic [$clog2(FIFO_DEPTH):0] f_level;
  logic         f_ready;
  salnk_word_t  f_in;
  logic         f_push;

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wr     = setup && pwrite;
  assign rd     = setup && !pwrite;

  // a non-startup node follows the startup node's word
  assign eff_param = startup_node ? s_q.param : net_param;
  assign mode      = salnk_mode_t'(eff_param[SALNK_POS_MODE +: 2]);
  // words per node doubles with each step of bits 7:6
  assign cio_w   = SALNK_CIO_MIN << eff_param[SALNK_POS_WPN +: 2];
  assign dm_w    = SALNK_DM_MIN  << eff_param[SALNK_POS_WPN +: 2];
  // fixed area divided evenly: 16, 8, 4 or 2 nodes
  assign n_nodes = 6'(SALNK_CIO_WORDS / cio_w);

  ////////////////////////////////////////////////////////////////////////////
  // generated entry, identical in every node; node n starts at base+(n-1)*w
  // auto_e follows the readback selector, lo_e the local node's own block
  always_comb begin
    auto_e = '0;
    lo_e   = '0;
    if (mode[0]) begin
      auto_e.cio_start = SALNK_CIO_BASE + 16'(s_q.tsel - 6'd1) * cio_w;
      auto_e.cio_cnt   = cio_w[7:0];
      lo_e.cio_start   = SALNK_CIO_BASE + 16'(s_q.node - 6'd1) * cio_w;
      lo_e.cio_cnt     = cio_w[7:0];
    end
    if (mode[1]) begin
      auto_e.dm_start  = SALNK_DM_BASE + 16'(s_q.tsel - 6'd1) * dm_w;
      auto_e.dm_cnt    = dm_w[7:0];
      lo_e.dm_start    = SALNK_DM_BASE + 16'(s_q.node - 6'd1) * dm_w;
      lo_e.dm_cnt      = dm_w[7:0];
    end
  end

  assign node_e = (mode == SALNK_MODE_MANUAL) ? tbl[s_q.node] : lo_e;

  ////////////////////////////////////////////////////////////////////////////
  // manual table check: used entries must chain without gaps
  always_comb begin
    logic        seen;
    logic [15:0] cio_nx, dm_nx;
    seen   = 1'b0;
    cio_nx = '0;
    dm_nx  = '0;
    tbl_ok = (s_q.used != '0);
    for (int i = 0; i < NODES; i++) begin
      if (s_q.used[i]) begin
        if (seen && (tbl[i].cio_start != cio_nx || tbl[i].dm_start != dm_nx)) begin
          tbl_ok = 1'b0;
        end
        seen   = 1'b1;
        cio_nx = tbl[i].cio_start + 16'(tbl[i].cio_cnt);
        dm_nx  = tbl[i].dm_start + 16'(tbl[i].dm_cnt);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d        = s_q;
    s_d.ready  = 1'b0;
    s_d.err    = 1'b0;
    s_d.tbl_we = 1'b0;
    s_d.node   = rotary_node;
    f_in       = '0;
    f_push     = 1'b0;
    if (wr) begin
      s_d.ready = 1'b1;
      unique case (paddr)
        SALNK_OFS_PARAM: s_d.param = pwdata[15:0];
        SALNK_OFS_TSEL:  s_d.tsel  = pwdata[5:0];
        SALNK_OFS_TABLE: begin
          // index in bits 31:26, entry packed below; stored tables back up manual mode
          if (pwdata[31:26] < 6'(NODES)) begin
            s_d.tbl_we  = 1'b1;
            s_d.tbl_idx = pwdata[31:26];
            s_d.tbl_wd  = {6'(0), pwdata[25:16], 8'(pwdata[15:8]), 16'(0), pwdata[7:0]};
            s_d.used[pwdata[31:26]] = (pwdata[15:8] != 8'h00) || (pwdata[7:0] != 8'h00);
          end else begin
            s_d.err = 1'b1;
          end
        end
        SALNK_OFS_FIFO: begin
          // word offset is relative to the local block, so other nodes' words are unreachable
          if (s_q.run && (pwdata[31] ? (pwdata[30:16] < 15'(node_e.dm_cnt))
                                     : (pwdata[30:16] < 15'(node_e.cio_cnt)))) begin
            f_push      = f_ready;
            f_in.is_dm  = pwdata[31];
            f_in.addr   = (pwdata[31] ? node_e.dm_start : node_e.cio_start)
                          + {1'b0, pwdata[30:16]};
            f_in.data   = pwdata[15:0];
            s_d.err     = !f_ready;
          end else begin
            s_d.err = 1'b1;
          end
        end
        default: s_d.err = 1'b1;
      endcase
    end
    if (rd) begin
      s_d.ready = 1'b1;
      s_d.rdata = '0;
      unique case (paddr)
        SALNK_OFS_PARAM:  s_d.rdata = {16'h0000, s_q.param};
        SALNK_OFS_STATUS: s_d.rdata = {28'(0), mode, s_q.valid, s_q.run};
        SALNK_OFS_NODE:   s_d.rdata = {26'(0), s_q.node};
        SALNK_OFS_TSEL:   s_d.rdata = {26'(0), s_q.tsel};
        SALNK_OFS_TRD:    s_d.rdata = (mode == SALNK_MODE_MANUAL)
                                      ? {tbl[s_q.tsel].cio_start[9:0], tbl[s_q.tsel].cio_cnt,
                                         6'(0), tbl[s_q.tsel].dm_cnt}
                                      : {auto_e.cio_start[9:0], auto_e.cio_cnt,
                                         6'(0), auto_e.dm_cnt};
        SALNK_OFS_FSTAT:  s_d.rdata = {26'(0), 6'(f_level)};
        default:          s_d.err   = 1'b1;
      endcase
    end
    ////////////////////////////////////////////////////////////////////////////
    // run control: bit 0 starts, clearing it stops; invalid settings never run
    s_d.valid = (mode == SALNK_MODE_MANUAL) ? tbl_ok
                : (s_q.node != 6'd0 && s_q.node <= n_nodes);
    unique case (s_q.st)
      SALNK_ST_IDLE: begin
        s_d.run = 1'b0;
        if (eff_param[SALNK_BIT_RUN]) begin
          s_d.st = SALNK_ST_CHECK;
        end
      end
      SALNK_ST_CHECK: begin
        if (!eff_param[SALNK_BIT_RUN]) begin
          s_d.st = SALNK_ST_IDLE;
        end else if (s_d.valid) begin
          s_d.st  = SALNK_ST_RUN;
          s_d.run = 1'b1;
        end
      end
      SALNK_ST_RUN: begin
        if (!eff_param[SALNK_BIT_RUN] || !s_d.valid) begin
          s_d.st  = eff_param[SALNK_BIT_RUN] ? SALNK_ST_CHECK : SALNK_ST_IDLE;
          s_d.run = 1'b0;
        end
      end
      default: begin
        s_d.st  = SALNK_ST_IDLE;
        s_d.run = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q       <= '0;
      s_q.param <= SALNK_PARAM_RST;
      s_q.node  <= SALNK_NODE_RST;
      s_q.tsel  <= SALNK_TSEL_RST;
      s_q.st    <= SALNK_ST_IDLE;
    end else begin
      s_q <= s_d;
    end
    if (s_q.tbl_we) begin
      tbl[s_q.tbl_idx] <= s_q.tbl_wd;
    end
  end

  assign prdata   = s_q.rdata;
  assign pready   = s_q.ready;
  assign pslverr  = s_q.err;
  assign link_run = s_q.run;

  ////////////////////////////////////////////////////////////////////////////
  // refresh words queue here; the network stalls by holding tx_ready low
  salnk_fifo #(
    .WIDTH ($bits(salnk_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_data   (f_in),
    .in_valid  (f_push),
    .in_ready  (f_ready),
    .out_data  (tx_word),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .level     (f_level)
  );
endmodule

/* tb/salnk_properties.sv */
// concurrent property checker bound to the link allocator top
`timescale 1ns/1ps
module salnk_checker
  import salnk_pkg::*;
(
  input wire logic        mclk,         // clock
  input wire logic        sys_rst,      // reset
  input wire logic        psel,         // select
  input wire logic        penable,      // enable
  input wire logic        pwrite,       // direction
  input wire logic [7:0]  paddr,        // address
  input wire logic [31:0] pwdata,       // write data
  input wire logic [31:0] prdata,       // read data
  input wire logic        pready,       // ready
  input wire logic        pslverr,      // error
  input wire logic [5:0]  rotary_node,  // switches
  input wire logic        startup_node, // startup
  input wire logic [15:0] net_param,    // net word
  input wire logic        link_run,     // running
  input wire logic [32:0] tx_word,      // word out
  input wire logic        tx_valid,     // valid
  input wire logic        tx_ready      // accept
);
  logic setup_c;
  logic wdone_c;
  logic run_bit_c;
  assign setup_c = psel && !penable;
  assign wdone_c = psel && penable && pready && pwrite;
  // last run bit written by the host into this node's own parameter word
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      run_bit_c <= 1'b0;
    end else if (wdone_c && paddr == SALNK_OFS_PARAM) begin
      run_bit_c <= pwdata[SALNK_BIT_RUN];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ans_next_a: assert property (setup_c |=> pready && penable)
    else $error("no answer after setup");
  ans_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (setup_c && paddr > 8'h1C |=> pslverr)
    else $error("unmapped access not refused");
  run_stop_a: assert property (wdone_c && startup_node && paddr == SALNK_OFS_PARAM
    && !pwdata[SALNK_BIT_RUN] |=> !link_run) else $error("links kept running");
  run_start_a: assert property ($rose(link_run) |->
    (startup_node ? run_bit_c : net_param[SALNK_BIT_RUN])) else $error("links started unasked");
  net_param_a: assert property (!startup_node && !net_param[0] |-> ##[0:2] !link_run)
    else $error("startup word ignored");
  idle_push_a: assert property (setup_c && pwrite && paddr == SALNK_OFS_FIFO
    && !link_run |=> pslverr) else $error("push accepted while stopped");
  table_idx_a: assert property (setup_c && pwrite && paddr == SALNK_OFS_TABLE
    && pwdata[31:26] >= 6'd62 |=> pslverr) else $error("table index not refused");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_word))
    else $error("word dropped while stalled");
  cover property (wdone_c && paddr == SALNK_OFS_PARAM);
  cover property ($rose(link_run));
  cover property (tx_valid && tx_ready);
endmodule
bind salnk_top salnk_checker i_salnk_checker (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rotary_node(rotary_node), .startup_node(startup_node),
  .net_param(net_param), .link_run(link_run), .tx_word(tx_word), .tx_valid(tx_valid),
  .tx_ready(tx_ready));

/* tb/salnk_net_model.sv */
// peer node model that accepts refresh words, promptly or stalled
`timescale 1ns/1ps
module salnk_net_model (
  input wire logic        mclk,     // clock
  input wire logic        sys_rst,  // reset
  input wire logic [32:0] tx_word,  // word in
  input wire logic        tx_valid, // valid
  input wire logic        stall,    // hold off
  output logic            tx_ready, // accept
  output logic [15:0]     count,    // words taken
  output logic [32:0]     last      // last word
);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_ready <= 1'b0;
      count <= 16'h0000;
      last <= '0;
    end else begin
      tx_ready <= !stall;
      if (tx_valid && tx_ready) begin
        count <= count + 16'h0001;
        last <= tx_word;
      end
    end
  end
endmodule

/* tb/tb_top.sv */
// self-checking bench for the link allocator
`timescale 1ns/1ps
module tb_top;
  import salnk_pkg::*;
  localparam int NODE = 2;
  logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic        startup_node, link_run, tx_valid, tx_ready, stall;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] net_param, count, got_n;
  logic [5:0]  rotary_node;
  logic [32:0] tx_word, last;
  int          mismatches, checked, cnt, base;
  salnk_top i_salnk_top (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rotary_node(rotary_node), .startup_node(startup_node),
    .net_param(net_param), .link_run(link_run), .tx_word(tx_word), .tx_valid(tx_valid),
    .tx_ready(tx_ready));
  salnk_net_model i_salnk_net_model (.mclk(mclk), .sys_rst(sys_rst), .tx_word(tx_word),
    .tx_valid(tx_valid), .stall(stall), .tx_ready(tx_ready), .count(count), .last(last));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task results;
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // request held until the edge that samples pready high; answer taken at that edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", 1, pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, {1'b0, e}, {1'b0, rd});
  endtask
  task wchk(input string nm, input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk(nm, e, err);
  endtask
  task runchk(input string nm, input logic [15:0] p, input logic e);
    wchk("param", SALNK_OFS_PARAM, {16'h0, p}, 1'b0);
    repeat (4) @(posedge mclk);
    chk(nm, e, link_run);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {sys_rst, startup_node} = 2'b11;
    {psel, penable, pwrite, stall} = 4'h0;
    {paddr, pwdata, net_param} = '0;
    rotary_node = 6'(NODE);
    mismatches = 0;
    checked = 0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    rchk("param rst", SALNK_OFS_PARAM, 32'h0);
    rchk("status rst", SALNK_OFS_STATUS, 32'h0);
    rchk("node", SALNK_OFS_NODE, 32'(NODE));
    rchk("tsel rst", SALNK_OFS_TSEL, 32'h1);
    rchk("fifo rst", SALNK_OFS_FSTAT, 32'h0);
    wchk("unmapped", 8'h20, 32'h0, 1'b1);
    wchk("idle push", SALNK_OFS_FIFO, 32'h0, 1'b1);
    for (int m = 1; m < 4; m++) begin
      for (int w = 0; w < 4; w++) begin
        runchk("auto run", {8'h0, w[1:0], m[1:0], 4'h1}, 1'b1);
        rchk("status", SALNK_OFS_STATUS, {28'h0, m[1:0], 2'b11});
        cnt = m[1] ? (8 << w) : (4 << w);
        base = m[1] ? int'(SALNK_DM_BASE) : int'(SALNK_CIO_BASE);
        wchk("push end", SALNK_OFS_FIFO, {m[1], 15'(cnt - 1), 16'(m * 16 + w)}, 1'b0);
        wchk("push over", SALNK_OFS_FIFO, {m[1], 15'(cnt), 16'h0}, 1'b1);
        repeat (6) @(posedge mclk);
        chk("tx word", {m[1], 16'(base + cnt * NODE - 1), 16'(m * 16 + w)}, last);
        runchk("stop", 16'h0000, 1'b0);
      end
    end
    rotary_node <= 6'd3;
    runchk("two nodes", 16'h00D1, 1'b0);
    rotary_node <= 6'd17;
    runchk("sixteen nodes", 16'h0011, 1'b0);
    rotary_node <= 6'(NODE);
    runchk("empty manual", 16'h0001, 1'b0);
    wchk("entry 1", SALNK_OFS_TABLE, {6'd1, 10'd0, 8'd4, 8'd0}, 1'b0);
    wchk("entry 2", SALNK_OFS_TABLE, {6'd2, 10'd4, 8'd4, 8'd0}, 1'b0);
    runchk("manual run", 16'h0001, 1'b1);
    rchk("table rd 1", SALNK_OFS_TRD, 32'h0001_0000);
    wchk("tsel", SALNK_OFS_TSEL, 32'h0000_0002, 1'b0);
    rchk("table rd 2", SALNK_OFS_TRD, 32'h0101_0000);
    wchk("entry gap", SALNK_OFS_TABLE, {6'd3, 10'd20, 8'd4, 8'd0}, 1'b0);
    runchk("gap refused", 16'h0001, 1'b0);
    wchk("entry 62", SALNK_OFS_TABLE, {6'd62, 26'h0}, 1'b1);
    runchk("stop", 16'h0000, 1'b0);
    @(posedge mclk);
    net_param <= 16'h0051;
    startup_node <= 1'b0;
    repeat (5) @(posedge mclk);
    chk("net run", 1, link_run);
    @(posedge mclk);
    net_param <= 16'h0050;
    repeat (3) @(posedge mclk);
    chk("net stop", 0, link_run);
    @(posedge mclk);
    startup_node <= 1'b1;
    stall <= 1'b1;
    runchk("fill run", 16'h00D1, 1'b1);
    got_n = count;
    for (int i = 0; i < 32; i++) wchk("fill", SALNK_OFS_FIFO, {1'b0, 15'(i), 16'(i)}, 1'b0);
    wchk("full", SALNK_OFS_FIFO, {1'b0, 15'd0, 16'hFFFF}, 1'b1);
    rchk("level full", SALNK_OFS_FSTAT, 32'd32);
    @(posedge mclk);
    stall <= 1'b0;
    repeat (45) @(posedge mclk);
    chk("drained", {17'h0, got_n + 16'd32}, {17'h0, count});
    chk("tail", {1'b0, 16'(1000 + 32 + 31), 16'd31}, last);
    rchk("level empty", SALNK_OFS_FSTAT, 32'h0);
    results;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    results;
  end
endmodule
